// [hw/dmcs_pkg.sv]
package dmcs_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int DMCS_CHARS = 20;
  localparam int DMCS_COLS = 5;
  localparam int DMCS_DOTS = 7;
  localparam int DMCS_RAM_WORDS = 100;
  localparam int DMCS_ADDR_W = 8;
  localparam int DMCS_DATA_W = 7;
  localparam int DMCS_SEL_W = 4;

  // ----------------------------------------
  // Address decode points
  // ----------------------------------------
  localparam logic [7:0] DMCS_ADDR_ZERO = 8'h00;
  localparam logic [7:0] DMCS_ADDR_COL1 = 8'h14;
  localparam logic [7:0] DMCS_ADDR_COL2 = 8'h28;
  localparam logic [7:0] DMCS_ADDR_COL3 = 8'h3C;
  localparam logic [7:0] DMCS_ADDR_COL4 = 8'h50;
  localparam logic [7:0] DMCS_ADDR_WRAP = 8'h64;
  localparam logic [7:0] DMCS_ADDR_MASTER_CLR = 8'h7F;
  localparam logic [7:0] DMCS_ADDR_CLR_END = 8'h80;
  localparam logic [7:0] DMCS_ADDR_ONE = 8'h01;

  // ----------------------------------------
  // Bit selector
  // ----------------------------------------
  localparam logic [3:0] DMCS_SEL_START = 4'h9;
  localparam logic [3:0] DMCS_SEL_TERM = 4'hF;
  localparam logic [3:0] DMCS_SEL_ONE = 4'h1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int DMCS_CLK_PERIOD_NS = 5;
  localparam int DMCS_DWELL_NS = 1500000;
  localparam int DMCS_DWELL_CYCLES = DMCS_DWELL_NS / DMCS_CLK_PERIOD_NS;
  localparam int DMCS_DWELL_W = 19;

  // ----------------------------------------
  // Column drive one-hot codes
  // ----------------------------------------
  localparam logic [4:0] DMCS_COL_NONE = 5'h00;
  localparam logic [4:0] DMCS_COL_1 = 5'h01;
  localparam logic [4:0] DMCS_COL_2 = 5'h02;
  localparam logic [4:0] DMCS_COL_3 = 5'h04;
  localparam logic [4:0] DMCS_COL_4 = 5'h08;
  localparam logic [4:0] DMCS_COL_5 = 5'h10;

  typedef struct packed {
    logic por_s1;
    logic por_s2;
    logic fb_s1;
    logic fb_s2;
    logic [7:0] addr;
    logic [3:0] bitsel;
    logic phase;
    logic shift_clk;
    logic serial_data;
    logic hold;
    logic dwell_done;
    logic [18:0] dwell;
    logic [4:0] cols;
    logic clear;
    logic addr_rst;
  } dmcs_state_type;

  // Host side write into column RAM
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [6:0] data;
  } dmcs_host_wr_type;

endpackage

// [hw/dmcs_scan.sv]
// Operation
// - Shift 140 bits before each column lights, bar column five right after reset or clear
// - Halt shifting, drive column for dwell
// - Column RAM of 100 seven-bit words
// - RAM holds columns in ascending octal blocks
// - Select seven bits, then advance address
// - Bit selector reloads octal 11 at top
// - Capture edge opposite to selector advance
// - Address zero drives column five first
// - Octal 24 holds clock, drives column one
// - Octal 50 and later boundaries repeat pattern
// - Octal 144 resets address to zero
// - Power-on clear zeroes address, writes RAM
// - Clear loop suppresses drivers, writes zeros
// - Octal 200 ends clear loop, resets address
// - Address octal 177 forces clear loop
`timescale 1ns/1ps
`default_nettype none

module dmcs_scan
  import dmcs_pkg::*;
#(
  parameter int unsigned DWELL_CYCLES = DMCS_DWELL_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Host RAM port
  input wire logic host_wr_en_i,
  input wire logic [7:0] host_wr_addr_i,
  input wire logic [6:0] host_wr_data_i,
  input wire logic ram_clear_request_i,
  // Pins from timer and feedback
  input wire logic power_on_clear_in_i,
  input wire logic clear_mode_feedback_in_i,
  // Display serial load
  output logic serial_data_o,
  output logic shift_clk_o,
  // Column drivers and status
  output logic [4:0] column_drive_o,
  output logic column1_drive_out_o,
  output logic column5_drive_out_o,
  output logic shift_clock_hold_out_o,
  output logic address_reset_out_o,
  output logic ram_write_enable_out_o
);

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic [4:0] col_of(input logic [7:0] a);
    logic [4:0] c;
    c = DMCS_COL_NONE;
    unique case (a)
      DMCS_ADDR_ZERO: c = DMCS_COL_5;
      DMCS_ADDR_COL1: c = DMCS_COL_1;
      DMCS_ADDR_COL2: c = DMCS_COL_2;
      DMCS_ADDR_COL3: c = DMCS_COL_3;
      DMCS_ADDR_COL4: c = DMCS_COL_4;
      default: c = DMCS_COL_NONE;
    endcase
    return c;
  endfunction

  function automatic logic in_ram(input logic [7:0] a);
    return a < 8'(DMCS_RAM_WORDS);
  endfunction

  function automatic logic is_boundary(input logic [7:0] a);
    return col_of(a) != DMCS_COL_NONE;
  endfunction

  function automatic logic sel_last(input logic [3:0] s);
    return s == DMCS_SEL_TERM;
  endfunction

  // Selector runs from its start state, so the bit index is the offset from it
  function automatic logic [2:0] sel_bit(input logic [3:0] s);
    logic [3:0] k;
    k = s - DMCS_SEL_START;
    return k[2:0];
  endfunction

  // ----------------------------------------
  // Column RAM
  // ----------------------------------------
  logic [DMCS_DATA_W-1:0] ram [DMCS_RAM_WORDS];
  dmcs_state_type q, d;
  dmcs_host_wr_type hw;
  logic [6:0] word;
  logic [2:0] bit_idx;
  logic ram_we;
  logic [6:0] ram_wa;
  logic [6:0] ram_wd;

  assign hw = '{en: host_wr_en_i, addr: host_wr_addr_i, data: host_wr_data_i};
  assign word = in_ram(q.addr) ? ram[q.addr[6:0]] : 7'h00;
  assign bit_idx = sel_bit(q.bitsel);

  // Single write port: the clear loop owns it, host writes then are dropped
  assign ram_we = q.clear ? in_ram(q.addr) : (hw.en && in_ram(hw.addr));
  assign ram_wa = q.clear ? q.addr[6:0] : hw.addr[6:0];
  assign ram_wd = q.clear ? 7'h00 : hw.data;

  always_ff @(posedge core_clk_i) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
  end

  // ----------------------------------------
  // Dwell timer
  // ----------------------------------------
  // One less is loaded so the column stays on for exactly DWELL_CYCLES clocks
  logic [18:0] dwell_load;
  logic dwell_over;

  assign dwell_load = 19'(DWELL_CYCLES - 1);
  assign dwell_over = q.dwell == '0;

  // ----------------------------------------
  // Scan conditions
  // ----------------------------------------
  logic por_active;
  logic fb_active;
  logic clear_start;
  logic at_master;
  logic at_clear_end;
  logic at_wrap;
  logic at_boundary;
  logic dwell_start;

  // Only the second synchroniser stages are decoded
  assign por_active = q.por_s2;
  assign fb_active = q.fb_s2;
  assign clear_start = ram_clear_request_i && !q.clear;
  assign at_master = q.addr == DMCS_ADDR_MASTER_CLR;
  assign at_clear_end = q.addr == DMCS_ADDR_CLR_END;
  assign at_wrap = q.addr == DMCS_ADDR_WRAP;
  assign at_boundary = is_boundary(q.addr);
  // A boundary is served once per visit, before its word's first bit
  assign dwell_start = !q.phase && !q.dwell_done && q.bitsel == DMCS_SEL_START && at_boundary;

  // ----------------------------------------
  // Scan sequencer
  // ----------------------------------------
  always_comb begin
    d = q;
    d.por_s1 = power_on_clear_in_i;
    d.por_s2 = q.por_s1;
    d.fb_s1 = clear_mode_feedback_in_i;
    d.fb_s2 = q.fb_s1;
    d.addr_rst = 1'b0;
    if (por_active) begin
      d.addr = DMCS_ADDR_ZERO;
      d.clear = 1'b1;
      d.hold = 1'b0;
      d.cols = DMCS_COL_NONE;
      d.bitsel = DMCS_SEL_START;
      d.phase = 1'b0;
      d.shift_clk = 1'b0;
      d.dwell_done = 1'b0;
      d.addr_rst = 1'b1;
    end else if (clear_start) begin
      d.addr = DMCS_ADDR_MASTER_CLR;
      d.hold = 1'b0;
      d.cols = DMCS_COL_NONE;
    end else if (q.clear) begin
      d.cols = DMCS_COL_NONE;
      if (at_clear_end) begin
        d.clear = 1'b0;
        d.addr = DMCS_ADDR_ZERO;
        d.addr_rst = 1'b1;
        d.dwell_done = 1'b0;
      end else begin
        d.addr = q.addr + DMCS_ADDR_ONE;
      end
    end else if (at_master) begin
      d.clear = 1'b1;
      d.addr = DMCS_ADDR_ZERO;
      d.addr_rst = 1'b1;
      d.cols = DMCS_COL_NONE;
      d.hold = 1'b0;
      d.bitsel = DMCS_SEL_START;
      d.phase = 1'b0;
      d.shift_clk = 1'b0;
    end else if (q.hold) begin
      // Shift clock frozen until the dwell runs out
      if (dwell_over) begin
        d.hold = 1'b0;
        d.cols = DMCS_COL_NONE;
      end else begin
        d.dwell = q.dwell - 19'h00001;
        // Feedback rising mid-dwell still darkens the lit column
        if (fb_active) begin
          d.cols = DMCS_COL_NONE;
        end
      end
    end else if (at_wrap) begin
      d.addr = DMCS_ADDR_ZERO;
      d.addr_rst = 1'b1;
      d.dwell_done = 1'b0;
    end else if (dwell_start) begin
      // Reached after the last bit's rising capture edge, except at address zero right after reset or clear
      d.hold = 1'b1;
      d.dwell_done = 1'b1;
      d.dwell = dwell_load;
      d.shift_clk = 1'b0;
      d.cols = fb_active ? DMCS_COL_NONE : col_of(q.addr);
    end else if (!q.phase) begin
      // Falling shift edge: new bit and selector step together
      d.serial_data = word[bit_idx];
      d.shift_clk = 1'b0;
      d.phase = 1'b1;
      d.cols = DMCS_COL_NONE;
      if (sel_last(q.bitsel)) begin
        d.bitsel = DMCS_SEL_START;
        d.addr = q.addr + DMCS_ADDR_ONE;
        d.dwell_done = 1'b0;
      end else begin
        d.bitsel = q.bitsel + DMCS_SEL_ONE;
      end
    end else begin
      // Rising edge: display captures the settled bit
      d.shift_clk = 1'b1;
      d.phase = 1'b0;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{
        por_s1: 1'b0,
        por_s2: 1'b0,
        fb_s1: 1'b0,
        fb_s2: 1'b0,
        addr: DMCS_ADDR_ZERO,
        bitsel: DMCS_SEL_START,
        phase: 1'b0,
        shift_clk: 1'b0,
        serial_data: 1'b0,
        hold: 1'b0,
        dwell_done: 1'b0,
        dwell: '0,
        cols: DMCS_COL_NONE,
        clear: 1'b0,
        addr_rst: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign serial_data_o = q.serial_data;
  assign shift_clk_o = q.shift_clk;
  // Column pins fan out bit by bit; bits 0 and 4 also have their own pins
  for (genvar i = 0; i < DMCS_COLS; i++) begin : g_col_pin
    assign column_drive_o[i] = q.cols[i];
  end
  assign column1_drive_out_o = q.cols[0];
  assign column5_drive_out_o = q.cols[4];
  assign shift_clock_hold_out_o = q.hold;
  assign address_reset_out_o = q.addr_rst;
  assign ram_write_enable_out_o = q.clear;

endmodule

`default_nettype wire

// [tb/dmcs_display.sv]
`timescale 1ns/1ps
`default_nettype none
module dmcs_display (
  // Serial load from the scan block
  input wire logic shift_clk_i,
  input wire logic serial_data_i,
  // Holding register, bit 0 is the first bit in
  output logic [139:0] dots_o
);
  initial dots_o = '0;
  // Rising edge capture, opposite to the selector step
  always @(posedge shift_clk_i) dots_o <= {serial_data_i, dots_o[139:1]};
endmodule
`default_nettype wire

// [tb/dmcs_scan_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module dmcs_scan_assertions
  import dmcs_pkg::*;
#(
  parameter int unsigned DWELL_CYCLES = DMCS_DWELL_CYCLES
) (
  // Watched ports
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic ram_clear_request_i,
  input wire logic power_on_clear_in_i,
  input wire logic shift_clk_o,
  input wire logic [4:0] column_drive_o,
  input wire logic shift_clock_hold_out_o,
  input wire logic address_reset_out_o,
  input wire logic ram_write_enable_out_o
);
  logic [18:0] dwl_q;
  logic [7:0] bit_q;
  logic sclk_q;
  // Hold length and shift clock rises since the last dwell
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dwl_q <= '0;
      bit_q <= '0;
      sclk_q <= 1'b0;
    end else begin
      dwl_q <= shift_clock_hold_out_o ? dwl_q + 19'h1 : '0;
      bit_q <= shift_clock_hold_out_o ? 8'h0 : bit_q + 8'(shift_clk_o && !sclk_q);
      sclk_q <= shift_clk_o;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_one; $onehot0(column_drive_o); endproperty
  a_one: assert property (p_one) else $error("two columns on");
  property p_lit; |column_drive_o |-> shift_clock_hold_out_o; endproperty
  a_lit: assert property (p_lit) else $error("column on while shifting");
  property p_halt; shift_clock_hold_out_o |-> !shift_clk_o; endproperty
  a_halt: assert property (p_halt) else $error("shift clock in dwell");
  // Clear entry may cut a dwell short, so only normal dwells are timed
  property p_dwell; $fell(shift_clock_hold_out_o) && !ram_write_enable_out_o && !$past(ram_clear_request_i) |->
    dwl_q == DWELL_CYCLES; endproperty
  a_dwell: assert property (p_dwell) else $error("dwell length");
  property p_bits; $rose(shift_clock_hold_out_o) && |column_drive_o[3:0] |->
    bit_q + 8'($rose(shift_clk_o)) == 8'h8C; endproperty
  a_bits: assert property (p_bits) else $error("bit count per column");
  property p_dark; ram_write_enable_out_o |-> column_drive_o == DMCS_COL_NONE; endproperty
  a_dark: assert property (p_dark) else $error("column in clear loop");
  property p_pulse; address_reset_out_o && !ram_write_enable_out_o |=> !address_reset_out_o; endproperty
  a_pulse: assert property (p_pulse) else $error("address reset too long");
  property p_end; $fell(ram_write_enable_out_o) |-> ##[0:1] address_reset_out_o; endproperty
  a_end: assert property (p_end) else $error("clear end without reset");
  property p_por; power_on_clear_in_i [*4] |=> ram_write_enable_out_o; endproperty
  a_por: assert property (p_por) else $error("power-on clear ignored");
  property p_req; ram_clear_request_i |-> ##[1:4] ram_write_enable_out_o; endproperty
  a_req: assert property (p_req) else $error("clear request ignored");
  c_col1: cover property ($rose(shift_clock_hold_out_o) && column_drive_o[0]);
  c_clr: cover property ($rose(ram_write_enable_out_o));
  c_wrap: cover property (address_reset_out_o && !ram_write_enable_out_o);
endmodule
bind dmcs_scan dmcs_scan_assertions #(.DWELL_CYCLES(DWELL_CYCLES)) chk (.core_clk_i, .resetn_i,
  .ram_clear_request_i, .power_on_clear_in_i, .shift_clk_o, .column_drive_o, .shift_clock_hold_out_o,
  .address_reset_out_o, .ram_write_enable_out_o);
`default_nettype wire

// [tb/tb_dot_matrix_column_scan.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_dot_matrix_column_scan;
  import dmcs_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, wen = 1'b0, creq = 1'b0, por = 1'b0, fb = 1'b0;
  logic [7:0] wad = 8'h00;
  logic [6:0] wdat = 7'h00;
  logic sdat, sclk, c1, c5, hold, arst, rwe;
  logic [4:0] col;
  logic [139:0] dots;
  logic [6:0] mem [100];
  int miscompares = 0, checked = 0, cyc = 0;
  dmcs_scan #(.DWELL_CYCLES(20)) dut (.core_clk_i(clk), .resetn_i(rstn), .host_wr_en_i(wen),
    .host_wr_addr_i(wad), .host_wr_data_i(wdat), .ram_clear_request_i(creq), .power_on_clear_in_i(por),
    .clear_mode_feedback_in_i(fb), .serial_data_o(sdat), .shift_clk_o(sclk), .column_drive_o(col),
    .column1_drive_out_o(c1), .column5_drive_out_o(c5), .shift_clock_hold_out_o(hold),
    .address_reset_out_o(arst), .ram_write_enable_out_o(rwe));
  dmcs_display disp (.shift_clk_i(sclk), .serial_data_i(sdat), .dots_o(dots));
  initial forever #2.5 clk = ~clk;
  // Run ceiling well above the few thousand cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
  end
  task automatic results();
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [139:0] got, input logic [139:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Last write goes to address 100, which must be dropped
  task automatic fill(input int k);
    for (int a = 0; a <= 100; a++) begin
      @(negedge clk);
      wen = 1'b1;
      wad = 8'(a);
      wdat = 7'(a * k + 11);
      if (a < 100) mem[a] = wdat;
    end
    @(negedge clk);
    wen = 1'b0;
  endtask
  task automatic wait_col(input logic [4:0] c);
    for (int n = 0; n < 2000 && col !== c; n++) @(negedge clk);
    chk(140'(col === c), 140'h1, "column not driven");
    chk(140'(c1 === col[0] && c5 === col[4]), 140'h1, "column pins");
  endtask
  task automatic wait_we(input logic v);
    for (int n = 0; n < 2000 && rwe !== v; n++) @(negedge clk);
    chk(140'(rwe === v), 140'h1, "write enable");
  endtask
  task automatic show(input int c);
    logic [139:0] e;
    for (int w = 0; w < 20; w++) e[7 * w +: 7] = mem[20 * c + w];
    wait_col(5'(1 << c));
    chk(dots, e, "column dots");
  endtask
  task automatic t_scan();
    fill(37);
    for (int n = 0; n < 2000 && arst !== 1'b1; n++) @(negedge clk);
    chk(140'(arst === 1'b1 && col === DMCS_COL_NONE), 140'h1, "wrap address reset");
    wait_col(DMCS_COL_5);
    for (int c = 0; c < 5; c++) show(c);
  endtask
  task automatic t_clear();
    while (hold !== 1'b0) @(negedge clk);
    creq = 1'b1;
    @(negedge clk);
    creq = 1'b0;
    wait_we(1'b1);
    wait_we(1'b0);
    chk(140'(arst === 1'b1), 140'h1, "address reset at clear end");
    for (int a = 0; a < 100; a++) mem[a] = 7'h00;
    show(0);
  endtask
  task automatic t_por();
    fill(91);
    while (hold !== 1'b0) @(negedge clk);
    por = 1'b1;
    repeat (10) @(negedge clk);
    chk(140'({rwe, col}), 140'h20, "power-on clear");
    por = 1'b0;
    wait_we(1'b0);
    chk(140'(arst === 1'b1), 140'h1, "address reset after power-on");
    for (int a = 0; a < 100; a++) mem[a] = 7'h00;
    show(1);
  endtask
  // Feedback is synchronised, so the first cycles are not judged
  task automatic t_fb();
    int lit;
    lit = 0;
    fill(53);
    fb = 1'b1;
    repeat (4) @(negedge clk);
    repeat (700) begin
      @(negedge clk);
      lit += int'(col !== DMCS_COL_NONE);
    end
    fb = 1'b0;
    chk(140'(lit), 140'h0, "drive under feedback");
    show(2);
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_scan();
    t_clear();
    t_por();
    t_fb();
    results();
  end
endmodule
`default_nettype wire
